// [rtl/bmadc_seq.sv]
// module: battery monitor converter sequencer
`timescale 1ns/1ps
module bmadc_seq (
  input  wire logic       i_core_clk,     // 125 MHz core clock
  input  wire logic       i_reset,        // async reset, high
  input  wire logic       i_tick_1k,      // 1 kHz crystal tick
  input  wire logic       i_sys_power_on, // system power state
  input  wire logic       i_power_switch, // power switch level
  input  wire logic       i_analog_trig,  // analog trigger input
  input  wire logic       i_adc_sdi,      // serial data from converter
  input  wire logic       i_ga_sdi,       // serial data from gate array
  input  wire logic [7:0] i_threshold,    // battery low threshold
  output logic            o_adc_supply,   // converter supply enable
  output logic            o_adc_select_n, // converter select, low=iface
  output logic            o_adc_sck,      // shift clock
  output logic            o_adc_sdo,      // serial data to converter
  output logic            o_ga_sck,       // shift clock to gate array
  output logic [7:0]      o_ga_cmd,       // fetched command
  output logic [7:0]      o_battery,      // last battery value
  output logic [7:0]      o_analog,       // last analog value
  output logic            o_result_valid, // one-cycle result strobe
  output logic            o_aux_backup,   // auxiliary backup enable
  output logic            o_lowv_irq,     // low-voltage interrupt req
  output logic            o_power_req     // power-on request pulse
);

  // two-flop synchronisers for pins
  // every pin is asynchronous to the core clock: the tick comes from
  // the crystal domain, the switch and trigger from the outside world,
  // the serial data lines from parts clocked by our own slow sck
  // only the second stage is read, so a metastable first stage
  // never reaches the sequencer
  logic [5:0] sync1;                      // first stage
  logic [5:0] sync2;                      // second stage
  logic [5:0] pins;                       // raw pin bundle
  bmadc_pkg::bmadc_s_t s;                 // registered state
  bmadc_pkg::bmadc_s_t next_s;            // next state

  assign pins = {i_tick_1k, i_sys_power_on, i_power_switch,
                 i_analog_trig, i_adc_sdi, i_ga_sdi};

  // synchroniser registers
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end

  // synchronised aliases
  logic tick_s;                           // ms tick level
  logic pwr_on_s;                         // system powered
  logic sw_s;                             // power switch level
  logic trig_s;                           // analog trigger level
  logic adc_sdi_s;                        // converter data in
  logic ga_sdi_s;                         // gate array data in
  assign tick_s    = sync2[5];
  assign pwr_on_s  = sync2[4];
  assign sw_s      = sync2[3];
  assign trig_s    = sync2[2];
  assign adc_sdi_s = sync2[1];
  assign ga_sdi_s  = sync2[0];

  // rising edge of the ms tick
  logic tick_rise;
  assign tick_rise = tick_s && !s.tick_last;

  // shift clock phase decode, used by each burst
  // true once the step counter has covered one half period of sck;
  // the caller clears the counter and flips the clock
  function automatic logic half_done(input logic [15:0] c);
    half_done = (c >= 16'(bmadc_pkg::HALF_CYC - 1));
  endfunction : half_done

  // sequencer next state
  // one measurement run, in core cycles:
  //   supply on, wait the settle time with select still high
  //   select low: interface mode
  //   powered only: eight gate array clocks fetch the command
  //   eight sck pulses send the channel byte, msb first
  //   select high half an sck period after the last rise, so the
  //   converter has taken the last channel bit before it converts
  //   select low again after the conversion time
  //   eight sck pulses clock the result in, msb first
  //   select high, result stored; a battery run also updates backup and irq
  //   supply off at once when powered or analog, otherwise when the
  //   supply window has run its length in ticks
  // sck idles high; data changes on the falling edge and is taken
  // on the rising edge, on both sides of the link
  always_comb begin
    next_s           = s;
    next_s.tick_last = tick_s;
    next_s.trig_last = trig_s;
    next_s.pwr_last  = sw_s;
    next_s.pwr_req   = 1'b0;
    next_s.done      = 1'b0;
    // switch change while off requests power-on
    if (!pwr_on_s && (sw_s != s.pwr_last))
      next_s.pwr_req = 1'b1;
    // analog trigger edge while powered
    if (pwr_on_s && trig_s && !s.trig_last)
      next_s.trig_pend = 1'b1;
    // window length counter
    if (tick_rise && s.st != bmadc_pkg::BMADC_IDLE)
      next_s.win_cnt = s.win_cnt + 16'h0001;
    case (s.st)
      bmadc_pkg::BMADC_IDLE: begin
        // idle link levels
        // supply off, select high, both shift clocks parked high;
        // the ms counter runs here only, so the period is
        // measured from the end of the previous window
        next_s.link = '{supply_en: 1'b0, select_n: 1'b1,
                        sck: 1'b1, sdo: 1'b0};
        next_s.ga_sck  = 1'b1;
        next_s.win_cnt = 16'h0000;
        next_s.cyc     = 16'h0000;
        if (tick_rise)
          next_s.tick_cnt = s.tick_cnt + 16'h0001;
        if (tick_rise && s.tick_cnt >=
            16'(bmadc_pkg::MEAS_PERIOD_MS - 1)) begin
          next_s.tick_cnt  = 16'h0000;
          next_s.is_analog = 1'b0;
          next_s.link.supply_en = 1'b1;
          next_s.st = bmadc_pkg::BMADC_SETTLE;
        end else if (s.trig_pend && pwr_on_s) begin
          next_s.trig_pend = 1'b0;
          next_s.is_analog = 1'b1;
          next_s.link.supply_en = 1'b1;
          next_s.st = bmadc_pkg::BMADC_SETTLE;
        end
      end
      bmadc_pkg::BMADC_SETTLE: begin
        // supply up, then enter interface mode
        // the settle wait lets the converter supply come up before
        // the first select edge reaches it
        next_s.cyc = s.cyc + 16'h0001;
        if (s.cyc >= 16'(bmadc_pkg::SETTLE_CYC - 1)) begin
          next_s.cyc = 16'h0000;
          next_s.link.select_n = 1'b0;
          next_s.bit_cnt = 4'h0;
          next_s.sh = s.is_analog ? bmadc_pkg::ANALOG_IN_CHANNEL
                                  : bmadc_pkg::BATTERY_SENSE_CHANNEL;
          next_s.st = pwr_on_s ? bmadc_pkg::BMADC_CMD
                               : bmadc_pkg::BMADC_SEL;
        end
      end
      bmadc_pkg::BMADC_CMD: begin
        // first burst: fetch command from gate array
        // converter sck stays parked, so the converter sees
        // nothing while the gate array is read
        // the gate array changes data on the falling edge
        next_s.cyc = s.cyc + 16'h0001;
        if (half_done(s.cyc)) begin
          next_s.cyc    = 16'h0000;
          next_s.ga_sck = !s.ga_sck;
          if (!s.ga_sck) begin
            next_s.cmd     = {s.cmd[6:0], ga_sdi_s};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
            if (s.bit_cnt == 4'(bmadc_pkg::BYTE_BITS - 1)) begin
              next_s.bit_cnt = 4'h0;
              next_s.st = bmadc_pkg::BMADC_SEL;
            end
          end
        end
      end
      bmadc_pkg::BMADC_SEL: begin
        // channel byte out, msb first, change on falling edge
        // bit_cnt counts rising edges; the eighth rise hands over
        // to the conversion step with select still low
        // sh was loaded with the channel code on entry
        next_s.cyc = s.cyc + 16'h0001;
        if (half_done(s.cyc)) begin
          next_s.cyc = 16'h0000;
          next_s.link.sck = !s.link.sck;
          if (s.link.sck) begin
            next_s.link.sdo = s.sh[7];
            next_s.sh = {s.sh[6:0], 1'b0};
          end else begin
            next_s.bit_cnt = s.bit_cnt + 4'h1;
            if (s.bit_cnt == 4'(bmadc_pkg::BYTE_BITS - 1)) begin
              next_s.bit_cnt = 4'h0;
              // select rises in the conversion step
              next_s.st = bmadc_pkg::BMADC_CONV;
            end
          end
        end
      end
      bmadc_pkg::BMADC_CONV: begin
        // conversion runs; result waits in converter
        // select rises half an sck period after the last channel
        // rise, never on the same edge, to keep the converter's
        // hold time on the eighth bit
        next_s.cyc = s.cyc + 16'h0001;
        if (half_done(s.cyc))
          next_s.link.select_n = 1'b1;
        if (s.cyc >= 16'(bmadc_pkg::CONV_CYC - 1)) begin
          next_s.cyc = 16'h0000;
          next_s.link.select_n = 1'b0;
          next_s.st = bmadc_pkg::BMADC_READ;
        end
      end
      bmadc_pkg::BMADC_READ: begin
        // clock result in, sample on rising edge
        // the first half period is a falling edge that makes the
        // converter present its msb; the synchroniser delay of two
        // cycles is small against the 125 cycle half period
        next_s.cyc = s.cyc + 16'h0001;
        if (half_done(s.cyc)) begin
          next_s.cyc = 16'h0000;
          next_s.link.sck = !s.link.sck;
          if (!s.link.sck) begin
            next_s.sh = {s.sh[6:0], adc_sdi_s};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
            if (s.bit_cnt == 4'(bmadc_pkg::BYTE_BITS - 1)) begin
              next_s.bit_cnt = 4'h0;
              next_s.st = bmadc_pkg::BMADC_DONE;
            end
          end
        end
      end
      bmadc_pkg::BMADC_DONE: begin
        // store result, evaluate battery; an off battery run holds until window ends
        // the store happens on the first cycle only, while select is
        // still low; afterwards select is high and nothing repeats
        // an analog run never touches the battery result or backup
        if (s.link.select_n == 1'b0) begin
          next_s.done = 1'b1;
          if (s.is_analog) begin
            next_s.analog = s.sh;
          end else begin
            next_s.result = s.sh;
            next_s.backup = (s.sh < i_threshold);
          end
        end
        next_s.link.select_n = 1'b1;
        next_s.link.sck      = 1'b1;
        if (s.is_analog || pwr_on_s ||
            s.win_cnt >= 16'(bmadc_pkg::WINDOW_TICKS)) begin
          next_s.link.supply_en = 1'b0;
          next_s.st = bmadc_pkg::BMADC_IDLE;
        end
      end
      default: begin
        next_s.st = bmadc_pkg::BMADC_IDLE;
      end
    endcase
    // interrupt request follows the low battery state while powered;
    // a low result taken while off is raised as soon as power comes
    next_s.lowv_irq = pwr_on_s && next_s.backup;
  end

  // state register
  // reset parks the link in its idle levels: supply off, select
  // high, both shift clocks high, so the converter sees no edge
  // when reset is released
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      s <= '0;
      s.link.select_n <= 1'b1;
      s.link.sck      <= 1'b1;
      s.ga_sck        <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state flops
  // plain wiring only, no logic between flop and pin
  always_comb begin
    o_adc_supply   = s.link.supply_en;
    o_adc_select_n = s.link.select_n;
    o_adc_sck      = s.link.sck;
    o_adc_sdo      = s.link.sdo;
    o_ga_sck       = s.ga_sck;
    o_ga_cmd       = s.cmd;
    o_battery      = s.result;
    o_analog       = s.analog;
    o_result_valid = s.done;
    o_aux_backup   = s.backup;
    o_lowv_irq     = s.lowv_irq;
    o_power_req    = s.pwr_req;
  end

endmodule : bmadc_seq

// [rtl/bmadc_pkg.sv]
// package: constants and carrier types of the battery monitor sequencer
package bmadc_pkg;
  // time base tick from crystal domain
  localparam int unsigned CLK_HZ          = 125000000;
  localparam int unsigned TICK_HZ         = 1000;
  // period between measurements while off, in seconds
  localparam int unsigned MEAS_PERIOD_S   = 10;
  localparam int unsigned MEAS_PERIOD_MS  = MEAS_PERIOD_S * 1000;
  // supply window length in us (7.5 ms)
  localparam int unsigned WINDOW_US       = 7500;
  localparam int unsigned WINDOW_TICKS    = (WINDOW_US * TICK_HZ) / 1000000;
  // settle time after supply before select, in us
  localparam int unsigned SETTLE_US       = 100;
  localparam int unsigned SETTLE_CYC      = (SETTLE_US * (CLK_HZ / 1000000));
  // conversion wait with select high
  localparam int unsigned CONV_US         = 200;
  localparam int unsigned CONV_CYC        = (CONV_US * (CLK_HZ / 1000000));
  // shift clock half period
  localparam int unsigned HALF_NS         = 1000;
  localparam int unsigned HALF_CYC        = (HALF_NS * (CLK_HZ / 1000000)) / 1000;
  // serial frame widths
  localparam int unsigned BYTE_BITS       = 8;
  // channel select codes
  localparam logic [7:0]  BATTERY_SENSE_CHANNEL = 8'h01;
  localparam logic [7:0]  ANALOG_IN_CHANNEL     = 8'h00;
  // default battery low threshold
  localparam logic [7:0]  LOW_THRESHOLD   = 8'h80;
  // counter widths
  localparam int unsigned CW              = 16;

  // sequencer states
  typedef enum logic [3:0] {
    BMADC_IDLE, BMADC_SETTLE, BMADC_CMD, BMADC_SEL, BMADC_CONV,
    BMADC_READ, BMADC_DONE
  } bmadc_state_t;

  // converter link outputs
  typedef struct packed {
    logic supply_en;                     // converter supply
    logic select_n;                      // low = interface mode
    logic sck;                           // shift clock
    logic sdo;                           // serial data to converter
  } bmadc_link_t;

  // whole module state
  typedef struct packed {
    bmadc_state_t st;                    // sequencer state
    bmadc_link_t  link;                  // link outputs
    logic [CW-1:0] tick_cnt;             // ms counter between measurements
    logic [CW-1:0] win_cnt;              // ms in current window
    logic [CW-1:0] cyc;                  // cycle counter within a step
    logic [3:0]    bit_cnt;              // bits shifted
    logic [7:0]    sh;                   // shift register
    logic [7:0]    cmd;                  // fetched gate array command
    logic [7:0]    result;               // last battery result
    logic [7:0]    analog;               // last analog result
    logic          is_analog;            // current run reads analog input
    logic          backup;               // auxiliary backup output
    logic          lowv_irq;             // low voltage request
    logic          pwr_req;              // power-on request pulse
    logic          pwr_last;             // previous switch level
    logic          tick_last;            // previous tick level
    logic          trig_last;            // previous trigger level
    logic          trig_pend;            // analog trigger pending
    logic          ga_sck;               // shift clock to gate array
    logic          done;                 // result strobe
  } bmadc_s_t;
endpackage : bmadc_pkg

// [verification/bmadc_adc_model.sv]
// model: serial converter on the far side of the link
`timescale 1ns/1ps
module bmadc_adc_model #(
  parameter logic [7:0] BATT_VAL = 8'h40, // battery reading
  parameter logic [7:0] ANA_VAL  = 8'hc3  // analog reading
) (
  input  wire logic       i_supply, // supply
  input  wire logic       i_sel_n,  // low = interface
  input  wire logic       i_sck,    // shift clock
  input  wire logic       i_sdi,    // channel bits in
  output logic            o_sdo,    // result bits out
  output logic [7:0]      o_chan,   // channel taken
  output logic [4:0]      o_bits    // clocks this window
);
  logic       rd; // frame reads result
  logic [7:0] sh; // result register
  // new window: first frame takes the channel
  always @(posedge i_supply) begin
    rd = 1'b0;
    o_bits = 5'h00;
  end
  // select high: convert, or release the line
  always @(posedge i_sel_n) begin
    o_sdo = ~o_sdo;
    if (!rd) begin
      sh = (o_chan == bmadc_pkg::BATTERY_SENSE_CHANNEL) ? BATT_VAL : ANA_VAL;
    end
    rd = ~rd;
  end
  // frame start: junk until first falling clock
  always @(negedge i_sel_n) o_sdo = ~o_sdo;
  // falling clock: next held result bit
  always @(negedge i_sck) if (rd && !i_sel_n) begin
    o_sdo = sh[7];
    sh = {sh[6:0], ~sh[7]};
  end
  // rising clock: count, take channel bits
  always @(posedge i_sck) if (!i_sel_n) begin
    o_bits = o_bits + 5'h01;
    if (!rd) o_chan = {o_chan[6:0], i_sdi};
  end
  initial o_sdo = 1'b1;
endmodule : bmadc_adc_model

// [verification/bmadc_seq_checker.sv]
// checker: port properties of the sequencer
`timescale 1ns/1ps
module bmadc_seq_checker (
  input wire logic       i_core_clk,     // clock
  input wire logic       i_reset,        // reset
  input wire logic [7:0] i_threshold,    // low level
  input wire logic       o_adc_supply,   // supply
  input wire logic       o_adc_select_n, // select
  input wire logic       o_adc_sck,      // shift clock
  input wire logic       o_adc_sdo,      // data out
  input wire logic [7:0] o_battery,      // battery value
  input wire logic       o_result_valid, // strobe
  input wire logic       o_aux_backup,   // backup
  input wire logic       o_lowv_irq,     // low voltage
  input wire logic       o_power_req     // switch pulse
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  logic seen; // a result was stored
  // note first stored result
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) seen <= 1'b0;
    else if (o_result_valid) seen <= 1'b1;
  end
  property p_sel; !o_adc_select_n |-> o_adc_supply; endproperty
  a_sel: assert property (p_sel) else $error("select without supply");
  property p_settle; $rose(o_adc_supply) |-> o_adc_select_n[*8]; endproperty
  a_settle: assert property (p_settle) else $error("select too soon");
  property p_idle; !o_adc_supply |-> o_adc_select_n && o_adc_sck; endproperty
  a_idle: assert property (p_idle) else $error("link not idle");
  property p_half; $fell(o_adc_sck) |-> !o_adc_sck[*8]; endproperty
  a_half: assert property (p_half) else $error("short clock");
  property p_hold; $rose(o_adc_sck) |-> $stable(o_adc_sdo); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_backup;
    seen && !o_result_valid && !$past(o_result_valid)
      |-> o_aux_backup == (o_battery < i_threshold);
  endproperty
  a_backup: assert property (p_backup) else $error("backup wrong");
  property p_lowv; o_lowv_irq |-> o_aux_backup; endproperty
  a_lowv: assert property (p_lowv) else $error("irq without low");
  property p_req; o_power_req |=> !o_power_req; endproperty
  a_req: assert property (p_req) else $error("request too long");
endmodule : bmadc_seq_checker
bind bmadc_seq bmadc_seq_checker u_chk (.i_core_clk, .i_reset, .i_threshold,
  .o_adc_supply, .o_adc_select_n, .o_adc_sck, .o_adc_sdo, .o_battery,
  .o_result_valid, .o_aux_backup, .o_lowv_irq, .o_power_req);

// [verification/bmadc_seq_tb.sv]
// testbench: sequencer against converter model
`timescale 1ns/1ps
module bmadc_seq_tb;
  logic clk = 0, rst = 1, tick = 0, pwr = 0, sw = 0, trig = 0, ga_sdi = 1;
  logic [7:0] thr = bmadc_pkg::LOW_THRESHOLD, ga_sh = 8'ha5, cmd, batt, ana;
  logic supply, sel_n, sck, sdo, ga_sck, valid, backup, lowv, preq, sdi;
  logic [7:0] chan;
  logic [4:0] nbits;
  int miscompares = 0, samples_checked = 0, ga_n = 0, n;
  always #4 clk = ~clk;
  always #62.5 tick = ~tick;
  bmadc_seq uut (.i_core_clk(clk), .i_reset(rst), .i_tick_1k(tick),
    .i_sys_power_on(pwr), .i_power_switch(sw), .i_analog_trig(trig),
    .i_adc_sdi(sdi), .i_ga_sdi(ga_sdi), .i_threshold(thr),
    .o_adc_supply(supply), .o_adc_select_n(sel_n), .o_adc_sck(sck),
    .o_adc_sdo(sdo), .o_ga_sck(ga_sck), .o_ga_cmd(cmd), .o_battery(batt),
    .o_analog(ana), .o_result_valid(valid), .o_aux_backup(backup),
    .o_lowv_irq(lowv), .o_power_req(preq));
  bmadc_adc_model adc (.i_supply(supply), .i_sel_n(sel_n), .i_sck(sck),
    .i_sdi(sdo), .o_sdo(sdi), .o_chan(chan), .o_bits(nbits));
  // gate array source: next bit on falling clock
  always @(negedge ga_sck) begin
    ga_sdi <= ga_sh[7];
    ga_sh <= {ga_sh[6:0], ga_sh[7]};
  end
  // count gate array clocks
  always @(posedge ga_sck) ga_n++;
  task automatic check(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic wait_for(ref logic s, input logic lvl, input int lim);
    n = 0;
    while (s !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) check("wait", 8'h01, 8'h00);
  endtask : wait_for
  // off-power window: period, channel, result, backup
  task automatic t_off_battery;
    wait_for(supply, 1'b1, 160000);
    check("period", 8'h01, {7'h0, n inside {[156200:156300]}});
    wait_for(valid, 1'b1, 50000);
    repeat (2) @(negedge clk);
    check("channel", bmadc_pkg::BATTERY_SENSE_CHANNEL, chan);
    check("clocks", 8'd16, {3'h0, nbits});
    check("battery", 8'h40, batt);
    check("backup", 8'h01, {7'h0, backup});
    check("lowv_off", 8'h00, {7'h0, lowv});
    wait_for(supply, 1'b0, 2000);
    check("idle", 8'h03, {6'h0, sel_n, sck});
  endtask : t_off_battery
  // powered: irq, then triggered analog run
  task automatic t_on_analog;
    pwr = 1'b1;
    repeat (8) @(negedge clk);
    check("lowv_on", 8'h01, {7'h0, lowv});
    ga_n = 0;
    trig = 1'b1;
    repeat (4) @(negedge clk);
    trig = 1'b0;
    wait_for(sck, 1'b0, 20000);
    check("cmd_clocks", 8'd8, 8'(ga_n));
    wait_for(valid, 1'b1, 50000);
    repeat (2) @(negedge clk);
    check("channel", bmadc_pkg::ANALOG_IN_CHANNEL, chan);
    check("analog", 8'hc3, ana);
    check("command", 8'ha5, cmd);
    check("battery_kept", 8'h40, batt);
  endtask : t_on_analog
  // power off: irq drops, switch changes pulse
  task automatic t_off_switch;
    pwr = 1'b0;
    repeat (8) @(negedge clk);
    check("lowv_clear", 8'h00, {7'h0, lowv});
    for (int k = 0; k < 2; k++) begin
      n = 0;
      sw = ~sw;
      repeat (10) begin
        @(negedge clk);
        n += preq;
      end
      check("power_req", 8'h01, 8'(n));
    end
  endtask : t_off_switch
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_off_battery;
    t_on_analog;
    t_off_switch;
    report_and_stop;
  end
  // watchdog
  initial begin
    repeat (300000) @(posedge clk);
    miscompares++;
    report_and_stop;
  end
endmodule : bmadc_seq_tb
